// ===== src/rgv_pkg.sv
package rgv_pkg;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CFG = 8'h08;
  localparam logic [7:0] OFF_PHC0 = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h20;
  localparam logic [7:0] OFF_STAT = 8'h24;
  // gain_limit_velocity_config fields
  localparam int HGL_LSB = 12;
  localparam int LGL_LSB = 8;
  localparam int VEL_LSB = 0;
  localparam logic [31:0] CFG_RST = 32'h0000_1901;
  localparam logic [31:0] CFG_WMASK = 32'h0000_FF07;
  // phase_compare_setting0 fields
  localparam int INTCLR_LSB = 24;
  localparam int IRS_BIT = 16;
  localparam logic [31:0] PHC0_RST = 32'h0000_0000;
  localparam logic [31:0] PHC0_WMASK = 32'h0001_0000;
  // control and status fields
  localparam int METHOD_BIT = 0;
  localparam int GAIN_INTEGRATOR_RESET_BIT = 1;
  localparam int ST_APPLIED_BIT = 0;
  localparam int ST_FREERUN_BIT = 1;
  localparam int ST_RES_LSB = 8;
  // converter clock the speed table refers to
  localparam int CONV_CLK_MHZ = 40;
  localparam logic [4:0] RES_BITS [0:7] = '{5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h10, 5'h0E, 5'h0C, 5'h0C};
  localparam logic [19:0] MAX_RPM [0:7] = '{20'h1D4C0, 20'h3A980, 20'h75300, 20'hEA600,
                                           20'h03A98, 20'h0EA60, 20'h3A980, 20'h3A980};

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } rgv_apb_req_t;

  typedef struct packed {
    logic [3:0] high_gain_limit;
    logic [3:0] low_gain_limit;
    logic [2:0] velocity_select;
    logic [4:0] resolution_bits;
    logic [19:0] max_speed_rpm;
    logic gain_method;
    logic free_running;
    logic gain_integrator_reset;
    logic match_latch_select;
    logic [2:0] match_clear;
  } rgv_core_cfg_t;
endpackage : rgv_pkg

// ===== src/rgv_config.sv
// Summary of operation
// - four-bit low gain limit at bits 11:8
// - four-bit high gain limit at bits 15:12
// - bits 7:3 reserved, read reset value
// - velocity select sets converter resolution
// - velocity select sets maximum tracking speed
// - unreset method change leaves angle free-running
// - phase compare register takes byte, half, word
//
// The register addresses and the APB register port were decided locally.
module rgv_config #(
  parameter int ADDR_W = rgv_pkg::ADDR_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // apb slave
  input wire rgv_pkg::rgv_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter core
  input wire logic [2:0] match_flags,
  output rgv_pkg::rgv_core_cfg_t core_cfg
);
  import rgv_pkg::*;

  generate
    if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_width
      $error("rgv_config: ADDR_W must be 6 to 8");
    end
  endgenerate

  logic [31:0] cfg_r, cfg_nxt;
  logic [31:0] phc0_r, phc0_nxt;
  logic [2:0] intclr_r, intclr_nxt;
  logic method_r, method_nxt;
  logic applied_r, applied_nxt;
  logic gain_integrator_reset_r, gain_integrator_reset_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  rgv_core_cfg_t cfg_out_r, cfg_out_nxt;

  // reset image of the core word; all zeros would pair velocity 0 with resolution 0
  localparam rgv_core_cfg_t CORE_RST = '{
    high_gain_limit: CFG_RST[HGL_LSB +: 4],
    low_gain_limit: CFG_RST[LGL_LSB +: 4],
    velocity_select: CFG_RST[VEL_LSB +: 3],
    resolution_bits: RES_BITS[CFG_RST[VEL_LSB +: 3]],
    max_speed_rpm: MAX_RPM[CFG_RST[VEL_LSB +: 3]],
    default: '0
  };

  // decode; one wait state keeps every answer registered
  wire logic [7:0] addr = 8'(apb_req.paddr[ADDR_W-1:0]);
  wire logic access = apb_req.psel & apb_req.penable;
  wire logic sel_cfg = addr == OFF_CFG;
  wire logic sel_phc0 = addr == OFF_PHC0;
  wire logic sel_ctrl = addr == OFF_CTRL;
  wire logic sel_stat = addr == OFF_STAT;
  wire logic mapped = sel_cfg | sel_phc0 | sel_ctrl | sel_stat;
  wire logic wr_done = access & pready_r & apb_req.pwrite & mapped;
  wire logic [31:0] bmask = {{8{apb_req.pstrb[3]}}, {8{apb_req.pstrb[2]}},
                             {8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};
  // reserved bits never stored, so they always read back zero
  wire logic [31:0] cfg_wm = bmask & CFG_WMASK;
  wire logic [31:0] phc0_wm = bmask & PHC0_WMASK;
  wire logic [2:0] intclr_wr = apb_req.pwdata[INTCLR_LSB +: 3] & {3{apb_req.pstrb[3]}};

  assign cfg_nxt = (wr_done & sel_cfg) ? ((cfg_r & ~cfg_wm) | (apb_req.pwdata & cfg_wm)) : cfg_r;
  assign phc0_nxt = (wr_done & sel_phc0) ? ((phc0_r & ~phc0_wm) | (apb_req.pwdata & phc0_wm)) : phc0_r;
  // clear strobes last one cycle
  assign intclr_nxt = (wr_done & sel_phc0) ? intclr_wr : 3'h0;
  assign method_nxt = (wr_done & sel_ctrl & apb_req.pstrb[0]) ? apb_req.pwdata[METHOD_BIT] : method_r;
  assign gain_integrator_reset_nxt = wr_done & sel_ctrl & apb_req.pstrb[0] & apb_req.pwdata[GAIN_INTEGRATOR_RESET_BIT];
  // the new method reaches the core only through an integrator reset
  assign applied_nxt = gain_integrator_reset_r ? method_r : applied_r;

  wire logic [2:0] vel = cfg_r[VEL_LSB +: 3];
  wire logic [31:0] stat_word = {19'h0, RES_BITS[vel], 6'h0,
                                 method_r != applied_r, applied_r};
  wire logic [31:0] phc0_word = phc0_r | {5'h0, intclr_r, 21'h0, match_flags};
  wire logic [31:0] rd_mux = sel_cfg ? cfg_r :
                             sel_phc0 ? phc0_word :
                             sel_ctrl ? {30'h0, gain_integrator_reset_r, method_r} :
                             sel_stat ? stat_word : 32'h0000_0000;

  assign pready_nxt = access & ~pready_r;
  assign pslverr_nxt = access & ~pready_r & ~mapped;
  assign prdata_nxt = (access & ~pready_r & ~apb_req.pwrite) ? rd_mux : prdata_r;

  always_comb begin
    cfg_out_nxt = '0;
    cfg_out_nxt.high_gain_limit = cfg_r[HGL_LSB +: 4];
    cfg_out_nxt.low_gain_limit = cfg_r[LGL_LSB +: 4];
    cfg_out_nxt.velocity_select = vel;
    cfg_out_nxt.resolution_bits = RES_BITS[vel];
    cfg_out_nxt.max_speed_rpm = MAX_RPM[vel];
    cfg_out_nxt.gain_method = applied_r;
    cfg_out_nxt.free_running = method_r != applied_r;
    cfg_out_nxt.gain_integrator_reset = gain_integrator_reset_r;
    cfg_out_nxt.match_latch_select = phc0_r[IRS_BIT];
    cfg_out_nxt.match_clear = intclr_r;
  end

  // register file
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfg_r <= CFG_RST;
      phc0_r <= PHC0_RST;
      intclr_r <= 3'h0;
      method_r <= 1'b0;
      applied_r <= 1'b0;
      gain_integrator_reset_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      phc0_r <= phc0_nxt;
      intclr_r <= intclr_nxt;
      method_r <= method_nxt;
      applied_r <= applied_nxt;
      gain_integrator_reset_r <= gain_integrator_reset_nxt;
    end
  end

  // bus answer
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // core word, one cycle behind the registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfg_out_r <= CORE_RST;
    end else begin
      cfg_out_r <= cfg_out_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign core_cfg = cfg_out_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_low_limit_write: assert property (
    wr_done && sel_cfg && apb_req.pstrb[1] |=> ##1 core_cfg.low_gain_limit == $past(apb_req.pwdata[11:8], 2))
    else $error("low gain limit not taken from write");
  a_high_limit_write: assert property (
    wr_done && sel_cfg && apb_req.pstrb[1] |=> ##1 core_cfg.high_gain_limit == $past(apb_req.pwdata[15:12], 2))
    else $error("high gain limit not taken from write");
  a_reserved_read_zero: assert property (
    access && !pready_r && sel_cfg && !apb_req.pwrite |=> prdata[7:3] == 5'h00)
    else $error("reserved config bits read nonzero");
  a_resolution_map: assert property (
    core_cfg.resolution_bits == RES_BITS[core_cfg.velocity_select])
    else $error("resolution does not match velocity select");
  a_speed_map: assert property (
    $changed(cfg_r[2:0]) |=> core_cfg.max_speed_rpm == MAX_RPM[$past(cfg_r[2:0])])
    else $error("maximum speed does not follow velocity select");
  a_method_held: assert property (
    $changed(method_r) && !gain_integrator_reset_r ##1 !gain_integrator_reset_r[*3] |-> core_cfg.gain_method == $past(applied_r, 3))
    else $error("method applied without integrator reset");
  a_freerun_flag: assert property (
    method_r != applied_r |=> core_cfg.free_running || $past(gain_integrator_reset_r))
    else $error("free running not flagged");
  a_byte_lane_keep: assert property (
    wr_done && sel_phc0 && !apb_req.pstrb[2] |=> phc0_r[IRS_BIT] == $past(phc0_r[IRS_BIT]))
    else $error("unselected byte lane was written");

  a_pready_one_cycle: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_pready_answers: assert property (
    access && !pready_r |=> pready)
    else $error("access phase not answered");
  a_error_with_ready: assert property (
    pslverr |-> pready)
    else $error("error flagged without ready");
  a_unmapped_no_write: assert property (
    access && pready_r && !mapped |=> $stable(cfg_r) && $stable(phc0_r) && $stable(method_r))
    else $error("unmapped write changed a register");
  a_irs_word_write: assert property (
    wr_done && sel_phc0 && apb_req.pstrb[2] |=> phc0_r[IRS_BIT] == $past(apb_req.pwdata[IRS_BIT]))
    else $error("select bit not taken from write");
  a_clear_one_cycle: assert property (
    wr_done && sel_phc0 && apb_req.pstrb[3] |=>
      intclr_r == $past(apb_req.pwdata[INTCLR_LSB +: 3]) ##1 intclr_r == 3'h0)
    else $error("clear strobe not a single pulse");
  a_clear_to_core: assert property (
    intclr_r != 3'h0 |=> core_cfg.match_clear == $past(intclr_r))
    else $error("clear strobe did not reach core");
  a_reserved_kept_zero: assert property (
    cfg_r[7:3] == 5'h00)
    else $error("reserved config bits stored");
  a_limits_follow: assert property (
    $changed(cfg_r[15:8]) |=> core_cfg.low_gain_limit == $past(cfg_r[11:8]) &&
      core_cfg.high_gain_limit == $past(cfg_r[15:12]))
    else $error("gain limits not passed to core");
  a_velocity_follow: assert property (
    $changed(cfg_r[2:0]) |=> core_cfg.velocity_select == $past(cfg_r[2:0]) &&
      core_cfg.resolution_bits == RES_BITS[$past(cfg_r[2:0])])
    else $error("velocity select not passed to core");
  a_status_resolution: assert property (
    access && !pready_r && sel_stat && !apb_req.pwrite |=> prdata[12:8] == RES_BITS[$past(cfg_r[2:0])])
    else $error("status resolution wrong");
  a_gain_integrator_reset_single: assert property (
    gain_integrator_reset_r |=> !gain_integrator_reset_r)
    else $error("integrator reset longer than one cycle");
  a_method_applies: assert property (
    gain_integrator_reset_r |=> applied_r == $past(method_r))
    else $error("integrator reset did not apply method");
endmodule : rgv_config

// ===== verif/rgv_core_model.sv
module rgv_core_model import rgv_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // bench and design side
  input wire logic [2:0] set_flags,
  input wire rgv_pkg::rgv_core_cfg_t core_cfg,
  output logic [2:0] match_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  // flags latch until a clear pulse, as a real core would hold them
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      match_flags <= 3'h0;
    end else begin
      match_flags <= (match_flags & ~core_cfg.match_clear) | set_flags;
    end
  end
endmodule : rgv_core_model

// ===== verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import rgv_pkg::*;
  logic ref_clk, reset_n, pready, pslverr, er;
  rgv_apb_req_t rq;
  logic [31:0] prdata, rd;
  logic [2:0] set_flags, match_flags;
  rgv_core_cfg_t cc;
  int fail_count, checks_done;
  int gain_integrator_reset_seen;
  logic [4:0] res_t [8] = '{5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h10, 5'h0E, 5'h0C, 5'h0C};
  logic [19:0] rpm_t [8] = '{20'h1D4C0, 20'h3A980, 20'h75300, 20'hEA600,
                             20'h03A98, 20'h0EA60, 20'h3A980, 20'h3A980};
  rgv_config DUT (.ref_clk(ref_clk), .reset_n(reset_n), .apb_req(rq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .match_flags(match_flags), .core_cfg(cc));
  rgv_core_model core (.ref_clk(ref_clk), .reset_n(reset_n), .set_flags(set_flags),
    .core_cfg(cc), .match_flags(match_flags));
  // integrator reset reaches the core as single-cycle pulses; count them
  always @(posedge ref_clk) begin
    if (cc.gain_integrator_reset === 1'b1) begin
      gain_integrator_reset_seen++;
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task summarize;
    $display("mismatches %0d checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one edge after release keeps back-to-back calls from double driving
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    rq <= '{1'b1, 1'b0, w, a, d, s};
    @(posedge ref_clk);
    rq.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    rq <= '0;
    @(posedge ref_clk);
  endtask : apb
  task wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt
  task t_vel;
    chk("rst_res", cc.resolution_bits, 32'h0C);
    apb(1'b0, OFF_CFG, 32'h0, 4'hF);
    chk("rst_cfg", rd, 32'h0000_1901);
    chk("err_ok", er, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFF_CFG, 32'h0000_1900 | i, 4'hF);
      wt(2);
      chk("res", cc.resolution_bits, res_t[i]);
      chk("rpm", cc.max_speed_rpm, rpm_t[i]);
      chk("vel", cc.velocity_select, i);
    end
  endtask : t_vel
  task t_gain;
    apb(1'b1, OFF_CFG, 32'h0000_3B02, 4'hF);
    wt(2);
    chk("high", cc.high_gain_limit, 32'h3);
    chk("low", cc.low_gain_limit, 32'hB);
    apb(1'b1, OFF_CFG, 32'h0000_19FF, 4'h2);
    apb(1'b0, OFF_CFG, 32'h0, 4'hF);
    chk("cfg_lane", rd, 32'h0000_1902);
  endtask : t_gain
  task t_method;
    apb(1'b1, OFF_CTRL, 32'h1, 4'h1);
    wt(2);
    chk("free", cc.free_running, 32'h1);
    chk("keep", cc.gain_method, 32'h0);
    chk("no_pulse", gain_integrator_reset_seen, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h3, 4'h1);
    wt(3);
    chk("applied", cc.gain_method, 32'h1);
    chk("one_pulse", gain_integrator_reset_seen, 32'h1);
    apb(1'b0, OFF_STAT, 32'h0, 4'hF);
    chk("stat", rd, 32'h0000_0B01);
  endtask : t_method
  task t_phc;
    set_flags <= 3'h5;
    wt(1);
    set_flags <= 3'h0;
    apb(1'b1, OFF_PHC0, 32'h0001_0000, 4'h4);
    apb(1'b0, OFF_PHC0, 32'h0, 4'hF);
    chk("phc_byte", rd, 32'h0001_0005);
    chk("irs", cc.match_latch_select, 32'h1);
    apb(1'b1, OFF_PHC0, 32'h0, 4'hC);
    apb(1'b1, OFF_PHC0, 32'h0500_0000, 4'h8);
    wt(3);
    apb(1'b0, OFF_PHC0, 32'h0, 4'hF);
    chk("phc_half", rd, 32'h0);
    apb(1'b1, OFF_PHC0, 32'h0001_0000, 4'hF);
    apb(1'b0, OFF_PHC0, 32'h0, 4'hF);
    chk("phc_word", rd, 32'h0001_0000);
  endtask : t_phc
  // unmapped place must refuse without side effects
  task t_unmap;
    apb(1'b1, 8'h30, 32'hFFFF_FFFF, 4'hF);
    chk("err_w", er, 32'h1);
    apb(1'b0, 8'h30, 32'h0, 4'hF);
    chk("rd_unm", rd, 32'h0);
    chk("err_r", er, 32'h1);
    apb(1'b0, OFF_CFG, 32'h0, 4'hF);
    chk("cfg_kept", rd, 32'h0000_1902);
  endtask : t_unmap
  initial begin
    rq = '0;
    reset_n = 1'b0;
    set_flags = 3'h0;
    fail_count = 0;
    checks_done = 0;
    gain_integrator_reset_seen = 0;
    wt(12);
    reset_n <= 1'b1;
    wt(2);
    t_vel();
    t_gain();
    t_method();
    t_phc();
    t_unmap();
    summarize();
  end
endmodule : testbench
